// *** design/acr_adc_control.sv ***
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RQ1: Conversions run only while the enable bit is 1; disabled starts nothing.
// RQ2: Standby-run bit 7 decides whether conversion continues during standby sleep.
// RQ3: Depth select 0 keeps the full ten-bit sample.
// RQ4: Depth select 1 drops two low bits, keeping eight upper bits.
// RQ5: Software sets continuous mode, then writes the trigger to start.
// RQ6: Continuous mode restarts a new conversion right after each completes.
// RQ7: Every completed conversion sets the conversion-done flag.
// RQ8: Accumulation count sums 1, 2, 4 up to 64 samples; code 7 reserved.
// RQ9: Reference select 0 is internal, 1 is supply; others reserved.
// RQ10: Converter clock is the peripheral clock divided by 2 to 256.
// RQ11: Capacitance bit 6 selects the reduced sampling capacitor when set.
// RQ12: The 16-bit result reads as low byte at 0x10, high byte next.
// RQ13: Trigger bit reads 1 while converting and clears itself when done; in continuous mode the code keeps it at 1.
// RQ14: Startup delay of 0 to 256 converter clocks precedes the first sample.
// RQ15: Window mode raises the window flag below, above, inside or outside.
// RQ16: Interrupt stays asserted while a flag and its enable are set.
// RQ17: Reserved control bits read zero; reserved accumulation code is avoided.
// RQ18: Sixteen-bit registers move through the staging byte atomically.
module acr_adc_control
	import acr_pkg::*;
(
	// Clock, reset and clock enable.
	input  wire logic                 core_clk_in,
	input  wire logic                 rstn_in,
	input  wire logic                 clk_en_in,
	// Wishbone slave.
	input  wire logic                 wb_cyc_in,
	input  wire logic                 wb_stb_in,
	input  wire logic                 wb_we_in,
	input  wire logic [7:0]           wb_adr_in,
	input  wire logic [3:0]           wb_sel_in,
	input  wire logic [31:0]          wb_dat_in,
	output logic      [31:0]          wb_dat_out,
	output logic                      wb_ack_out,
	// System state and start event.
	input  wire logic                 standby_in,
	input  wire logic                 debug_halt_in,
	input  wire logic                 start_event_in,
	// Analog front end.
	input  wire logic                 sample_valid_in,
	input  wire logic [ACR_RAW_W-1:0] sample_data_in,
	output acr_analog_type            analog_out,
	output logic                      converter_clk_out,
	// Interrupt.
	output logic                      irq_out
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Number of samples summed into one conversion.
	function automatic logic [6:0] acr_sample_total(input logic [2:0] code);
		logic [6:0] total;
		total = 7'h01;
		if (code <= ACR_ACC_MAX) begin
			total = 7'(7'h01 << code); // RQ8
		end
		return total;
	endfunction

	// Startup delay in converter clock ticks.
	function automatic logic [8:0] acr_delay_ticks(input logic [2:0] code);
		logic [8:0] ticks;
		ticks = 9'h000;
		if (code != 3'h0 && code <= ACR_DLY_MAX) begin
			ticks = 9'(ACR_DLY_BASE << (code - 3'h1)); // RQ14
		end
		return ticks;
	endfunction

	// Sample as it enters the accumulator.
	function automatic logic [15:0] acr_depth(input logic [ACR_RAW_W-1:0] raw, input logic eight);
		logic [15:0] value;
		value = 16'(raw); // RQ3
		if (eight) begin
			value = 16'(raw[ACR_RAW_W-1:2]); // RQ4
		end
		return value;
	endfunction

	// Window compare of a finished result.
	function automatic logic acr_window_hit(input logic [2:0] mode, input logic [15:0] value,
		input logic [15:0] low, input logic [15:0] high);
		logic hit;
		hit = 1'b0;
		unique case (mode) // RQ15
			ACR_WIN_BELOW:   hit = value < low;
			ACR_WIN_ABOVE:   hit = value > high;
			ACR_WIN_INSIDE:  hit = (value > low) && (value < high);
			ACR_WIN_OUTSIDE: hit = (value < low) || (value > high);
			default:         hit = 1'b0;
		endcase
		return hit;
	endfunction

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0]     ctrl_main;
	logic [2:0]     accumulation_count;
	logic [7:0]     ctrl_refck;
	logic [7:0]     ctrl_delay;
	logic [2:0]     window_compare_mode;
	logic [4:0]     sample_len;
	logic [4:0]     input_select;
	logic           event_start_en;
	logic [1:0]     interrupt_enable;
	logic [1:0]     interrupt_flag_reg;
	logic           debug_run;
	logic           duty_tuning;
	logic [7:0]     byte_staging;
	logic [15:0]    conversion_output;
	logic [15:0]    window_low_threshold;
	logic [15:0]    window_high_threshold;
	logic           conversion_trigger;
	logic           init_pending;
	logic           event_q;
	logic [ACR_DIV_W-1:0] div_cnt;
	logic [8:0]     dly_cnt;
	logic [6:0]     sample_cnt;
	logic [15:0]    accum;
	acr_state_type  state;
	acr_state_type  next_state;
	logic [7:0]     rd_byte;
	logic [7:0]     div_mask;
	logic [1:0]     flag_set;
	logic           acc_go;
	logic           wr_go;
	logic           rd_go;
	logic [5:0]     idx;
	logic [7:0]     wd;
	logic           enable;
	logic           run_ok;
	logic           tick;
	logic           start_req;
	logic           last_sample;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------

	// A request is taken in the cycle before the acknowledge.
	assign acc_go = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	assign wr_go  = acc_go & wb_we_in & wb_sel_in[0];
	assign rd_go  = acc_go & ~wb_we_in;
	assign idx    = wb_adr_in[7:2];
	assign wd     = wb_dat_in[7:0];
	assign enable = ctrl_main[ACR_BIT_ENABLE];

	// Sequencer may advance only when not held by standby or debug halt.
	assign run_ok = enable
		& ~(standby_in & ~ctrl_main[ACR_BIT_STBY_RUN]) // RQ2
		& ~(debug_halt_in & ~debug_run);

	// Software or event start; ignored while disabled.
	assign start_req = enable & ((wr_go & (idx == ACR_IDX_COMMAND) & wd[0]) // RQ5
		| (event_start_en & start_event_in & ~event_q)) ; // RQ1

	// Converter clock tick from the power-of-two prescaler.
	assign div_mask = 8'((9'h002 << ctrl_refck[2:0]) - 9'h001); // RQ10
	assign tick     = (div_cnt & div_mask) == div_mask;

	assign last_sample = (sample_cnt + 7'h01) == acr_sample_total(accumulation_count);

	// Hardware flag events of the finishing cycle.
	assign flag_set[ACR_BIT_DONE] = state == ACR_ST_DONE; // RQ7
	assign flag_set[ACR_BIT_WIN]  = (state == ACR_ST_DONE)
		& acr_window_hit(window_compare_mode, accum, window_low_threshold, window_high_threshold);

	// ------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------

	// Reserved bits and unmapped indices read as zero.
	always_comb begin
		rd_byte = ACR_RESET_BYTE;
		unique case (idx)
			ACR_IDX_CTRL_MAIN:  rd_byte = ctrl_main; // RQ17
			ACR_IDX_CTRL_ACC:   rd_byte = {5'h00, accumulation_count};
			ACR_IDX_CTRL_REFCK: rd_byte = ctrl_refck;
			ACR_IDX_CTRL_DLY:   rd_byte = ctrl_delay;
			ACR_IDX_CTRL_WIN:   rd_byte = {5'h00, window_compare_mode};
			ACR_IDX_SAMP_LEN:   rd_byte = {3'h0, sample_len};
			ACR_IDX_IN_SEL:     rd_byte = {3'h0, input_select};
			ACR_IDX_COMMAND:    rd_byte = {7'h00, conversion_trigger}; // RQ13
			ACR_IDX_EVT_CTRL:   rd_byte = {7'h00, event_start_en};
			ACR_IDX_INT_EN:     rd_byte = {6'h00, interrupt_enable};
			ACR_IDX_INT_FLAG:   rd_byte = {6'h00, interrupt_flag_reg};
			ACR_IDX_DBG_CTRL:   rd_byte = {7'h00, debug_run};
			ACR_IDX_STAGING:    rd_byte = byte_staging;
			ACR_IDX_RESULT_LO:  rd_byte = conversion_output[7:0]; // RQ12
			ACR_IDX_RESULT_HI:  rd_byte = byte_staging; // RQ18
			ACR_IDX_WLOW_LO:    rd_byte = window_low_threshold[7:0];
			ACR_IDX_WLOW_HI:    rd_byte = byte_staging;
			ACR_IDX_WHIGH_LO:   rd_byte = window_high_threshold[7:0];
			ACR_IDX_WHIGH_HI:   rd_byte = byte_staging;
			ACR_IDX_TUNING:     rd_byte = {7'h00, duty_tuning};
			default:            rd_byte = ACR_RESET_BYTE;
		endcase
	end

	// ------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------

	// Every access, mapped or not, is acknowledged one cycle after it is taken.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end else if (clk_en_in) begin
			wb_ack_out <= acc_go;
			if (rd_go) begin
				wb_dat_out <= {24'h00_0000, rd_byte};
			end
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------

	// Plain software-written fields; reserved bits are masked on write.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_main           <= ACR_RESET_BYTE;
			accumulation_count  <= 3'h0;
			ctrl_refck          <= ACR_RESET_BYTE;
			ctrl_delay          <= ACR_RESET_BYTE;
			window_compare_mode <= ACR_WIN_NONE;
			sample_len          <= 5'h00;
			input_select        <= 5'h00;
			event_start_en      <= 1'b0;
			interrupt_enable    <= 2'h0;
			debug_run           <= 1'b0;
			duty_tuning         <= 1'b0;
		end else if (clk_en_in && wr_go) begin
			unique case (idx)
				ACR_IDX_CTRL_MAIN:  ctrl_main <= wd & ACR_MASK_MAIN; // RQ17
				ACR_IDX_CTRL_ACC:   accumulation_count <= wd[2:0];
				ACR_IDX_CTRL_REFCK: ctrl_refck <= wd & ACR_MASK_REFCK; // RQ9 RQ11
				ACR_IDX_CTRL_DLY:   ctrl_delay <= wd;
				ACR_IDX_CTRL_WIN:   window_compare_mode <= wd[2:0];
				ACR_IDX_SAMP_LEN:   sample_len <= wd[4:0];
				ACR_IDX_IN_SEL:     input_select <= wd[4:0];
				ACR_IDX_EVT_CTRL:   event_start_en <= wd[0];
				ACR_IDX_INT_EN:     interrupt_enable <= wd[1:0];
				ACR_IDX_DBG_CTRL:   debug_run <= wd[0];
				ACR_IDX_TUNING:     duty_tuning <= wd[0];
				default:            ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Staging byte and window thresholds
	// ------------------------------------------------------------

	// Low-byte reads park the high byte; high-byte writes join the parked low byte.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			byte_staging          <= ACR_RESET_BYTE;
			window_low_threshold  <= ACR_RESET_WORD;
			window_high_threshold <= ACR_RESET_WORD;
		end else if (clk_en_in) begin
			if (rd_go) begin
				unique case (idx) // RQ18
					ACR_IDX_RESULT_LO: byte_staging <= conversion_output[15:8];
					ACR_IDX_WLOW_LO:   byte_staging <= window_low_threshold[15:8];
					ACR_IDX_WHIGH_LO:  byte_staging <= window_high_threshold[15:8];
					default:           ;
				endcase
			end else if (wr_go) begin
				unique case (idx) // RQ18
					ACR_IDX_STAGING:  byte_staging <= wd;
					ACR_IDX_WLOW_LO:  byte_staging <= wd;
					ACR_IDX_WHIGH_LO: byte_staging <= wd;
					ACR_IDX_WLOW_HI:  window_low_threshold <= {wd, byte_staging};
					ACR_IDX_WHIGH_HI: window_high_threshold <= {wd, byte_staging};
					default:          ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt flags
	// ------------------------------------------------------------

	// A read of the flag register clears it; a same-cycle event still sets.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			interrupt_flag_reg <= 2'h0;
		end else if (clk_en_in) begin
			if (rd_go && idx == ACR_IDX_INT_FLAG) begin
				interrupt_flag_reg <= flag_set; // RQ7
			end else begin
				interrupt_flag_reg <= interrupt_flag_reg | flag_set; // RQ16
			end
		end
	end

	// Level request while any enabled flag stands.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_out <= 1'b0;
		end else if (clk_en_in) begin
			irq_out <= |(interrupt_flag_reg & interrupt_enable); // RQ16
		end
	end

	// ------------------------------------------------------------
	// Converter clock prescaler
	// ------------------------------------------------------------

	// Free-running divider while run_ok is high; its selected bit is the converter clock.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			div_cnt           <= '0;
			converter_clk_out <= 1'b0;
		end else if (clk_en_in) begin
			if (run_ok) begin
				div_cnt <= div_cnt + 1'b1;
			end else begin
				div_cnt <= '0;
			end
			converter_clk_out <= run_ok & div_cnt[ctrl_refck[2:0]]; // RQ10
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------

	// Next state of the conversion sequencer.
	always_comb begin
		next_state = state;
		unique case (state)
			ACR_ST_IDLE: begin
				if (conversion_trigger && run_ok) begin
					if (init_pending && acr_delay_ticks(ctrl_delay[7:5]) != 9'h000) begin
						next_state = ACR_ST_INIT; // RQ14
					end else begin
						next_state = ACR_ST_SAMPLE;
					end
				end
			end
			ACR_ST_INIT: begin
				if (run_ok && tick && dly_cnt == 9'h001) begin
					next_state = ACR_ST_SAMPLE;
				end
			end
			ACR_ST_SAMPLE: begin
				if (run_ok && sample_valid_in && last_sample) begin
					next_state = ACR_ST_DONE; // RQ8
				end
			end
			ACR_ST_DONE: begin
				if (ctrl_main[ACR_BIT_CONT]) begin
					next_state = ACR_ST_SAMPLE; // RQ6
				end else begin
					next_state = ACR_ST_IDLE;
				end
			end
			default: next_state = ACR_ST_IDLE;
		endcase
		if (!enable) begin
			next_state = ACR_ST_IDLE; // RQ1
		end
	end

	// State register; a standby or debug hold freezes it in place.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= ACR_ST_IDLE;
		end else if (clk_en_in && (run_ok || !enable)) begin
			state <= next_state; // RQ2
		end
	end

	// Trigger bit: set by a start, cleared at completion unless continuous.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			conversion_trigger <= 1'b0;
		end else if (clk_en_in) begin
			if (!enable) begin
				conversion_trigger <= 1'b0; // RQ1
			end else if (start_req) begin
				conversion_trigger <= 1'b1; // RQ13
			end else if (state == ACR_ST_DONE && !ctrl_main[ACR_BIT_CONT]) begin
				conversion_trigger <= 1'b0; // RQ13
			end
		end
	end

	// Start event edge detect and the first-conversion delay marker.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			event_q      <= 1'b0;
			init_pending <= 1'b1;
		end else if (clk_en_in) begin
			event_q <= start_event_in;
			if (!enable) begin
				init_pending <= 1'b1;
			end else if (state == ACR_ST_IDLE && next_state != ACR_ST_IDLE) begin
				init_pending <= 1'b0;
			end
		end
	end

	// Startup delay counter in converter clock ticks.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dly_cnt <= 9'h000;
		end else if (clk_en_in) begin
			if (state == ACR_ST_IDLE) begin
				dly_cnt <= acr_delay_ticks(ctrl_delay[7:5]); // RQ14
			end else if (state == ACR_ST_INIT && run_ok && tick) begin
				dly_cnt <= dly_cnt - 9'h001;
			end
		end
	end

	// Accumulator and sample counter; cleared before each conversion.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			accum      <= ACR_RESET_WORD;
			sample_cnt <= 7'h00;
		end else if (clk_en_in) begin
			if (state != ACR_ST_SAMPLE) begin
				if (state == ACR_ST_DONE || state == ACR_ST_IDLE) begin
					accum      <= ACR_RESET_WORD;
					sample_cnt <= 7'h00;
				end
			end else if (run_ok && sample_valid_in) begin
				accum      <= accum + acr_depth(sample_data_in, ctrl_main[ACR_BIT_DEPTH]); // RQ3 RQ4 RQ8
				sample_cnt <= sample_cnt + 7'h01;
			end
		end
	end

	// Result register takes the finished sum.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			conversion_output <= ACR_RESET_WORD;
		end else if (clk_en_in && state == ACR_ST_DONE) begin
			conversion_output <= accum; // RQ12
		end
	end

	// Settings and sample request registered toward the front end.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			analog_out <= '0;
		end else if (clk_en_in) begin
			analog_out.sample_req        <= (next_state == ACR_ST_SAMPLE) && run_ok;
			analog_out.channel           <= input_select;
			analog_out.reference_select  <= ctrl_refck[5:4]; // RQ9
			analog_out.sample_cap_select <= ctrl_refck[ACR_BIT_CAP]; // RQ11
			analog_out.sample_len        <= sample_len;
			analog_out.sample_delay      <= ctrl_delay[3:0];
		end
	end

endmodule

`default_nettype wire

// *** design/acr_pkg.sv ***
package acr_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [5:0] ACR_IDX_CTRL_MAIN  = 6'h00;
	localparam logic [5:0] ACR_IDX_CTRL_ACC   = 6'h01;
	localparam logic [5:0] ACR_IDX_CTRL_REFCK = 6'h02;
	localparam logic [5:0] ACR_IDX_CTRL_DLY   = 6'h03;
	localparam logic [5:0] ACR_IDX_CTRL_WIN   = 6'h04;
	localparam logic [5:0] ACR_IDX_SAMP_LEN   = 6'h05;
	localparam logic [5:0] ACR_IDX_IN_SEL     = 6'h06;
	localparam logic [5:0] ACR_IDX_COMMAND    = 6'h08;
	localparam logic [5:0] ACR_IDX_EVT_CTRL   = 6'h09;
	localparam logic [5:0] ACR_IDX_INT_EN     = 6'h0a;
	localparam logic [5:0] ACR_IDX_INT_FLAG   = 6'h0b;
	localparam logic [5:0] ACR_IDX_DBG_CTRL   = 6'h0c;
	localparam logic [5:0] ACR_IDX_STAGING    = 6'h0d;
	localparam logic [5:0] ACR_IDX_RESULT_LO  = 6'h10;
	localparam logic [5:0] ACR_IDX_RESULT_HI  = 6'h11;
	localparam logic [5:0] ACR_IDX_WLOW_LO    = 6'h12;
	localparam logic [5:0] ACR_IDX_WLOW_HI    = 6'h13;
	localparam logic [5:0] ACR_IDX_WHIGH_LO   = 6'h14;
	localparam logic [5:0] ACR_IDX_WHIGH_HI   = 6'h15;
	localparam logic [5:0] ACR_IDX_TUNING     = 6'h16;

	// ------------------------------------------------------------
	// Field positions, masks and reset values
	// ------------------------------------------------------------
	localparam int unsigned ACR_BIT_ENABLE   = 0;
	localparam int unsigned ACR_BIT_CONT     = 1;
	localparam int unsigned ACR_BIT_DEPTH    = 2;
	localparam int unsigned ACR_BIT_STBY_RUN = 7;
	localparam int unsigned ACR_BIT_CAP      = 6;
	localparam int unsigned ACR_BIT_DONE     = 0;
	localparam int unsigned ACR_BIT_WIN      = 1;
	localparam logic [7:0] ACR_MASK_MAIN  = 8'h87;
	localparam logic [7:0] ACR_MASK_REFCK = 8'h77;
	localparam logic [7:0] ACR_RESET_BYTE = 8'h00;
	localparam logic [15:0] ACR_RESET_WORD = 16'h0000;

	// Converter widths and counts.
	localparam int unsigned ACR_RAW_W   = 10;
	localparam int unsigned ACR_DIV_W   = 8;
	localparam logic [8:0]  ACR_DLY_BASE = 9'h010;
	localparam logic [2:0]  ACR_ACC_MAX  = 3'h6;
	localparam logic [2:0]  ACR_DLY_MAX  = 3'h5;

	// ------------------------------------------------------------
	// Window compare modes and sequencer states
	// ------------------------------------------------------------
	localparam logic [2:0] ACR_WIN_NONE    = 3'h0;
	localparam logic [2:0] ACR_WIN_BELOW   = 3'h1;
	localparam logic [2:0] ACR_WIN_ABOVE   = 3'h2;
	localparam logic [2:0] ACR_WIN_INSIDE  = 3'h3;
	localparam logic [2:0] ACR_WIN_OUTSIDE = 3'h4;

	typedef enum logic [3:0] {
		ACR_ST_IDLE   = 4'b0001,
		ACR_ST_INIT   = 4'b0010,
		ACR_ST_SAMPLE = 4'b0100,
		ACR_ST_DONE   = 4'b1000
	} acr_state_type;

	// Settings handed to the analog front end.
	typedef struct packed {
		logic       sample_req;
		logic [4:0] channel;
		logic [1:0] reference_select;
		logic       sample_cap_select;
		logic [4:0] sample_len;
		logic [3:0] sample_delay;
	} acr_analog_type;

endpackage

// *** bench/acr_adc_control_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Bus, read data and interrupt checker
// ------------------------------------------------------------
module acr_adc_control_chk
	import acr_pkg::*;
(
	// Clock, reset and clock enable.
	input wire logic           core_clk_in,
	input wire logic           rstn_in,
	input wire logic           clk_en_in,
	// Bus and block outputs.
	input wire logic           wb_cyc_in,
	input wire logic           wb_stb_in,
	input wire logic           wb_we_in,
	input wire logic [7:0]     wb_adr_in,
	input wire logic [3:0]     wb_sel_in,
	input wire logic [31:0]    wb_dat_out,
	input wire logic           wb_ack_out,
	input wire acr_analog_type analog_out,
	input wire logic           irq_out
);
	// Decoded bus requests.
	wire logic req     = wb_cyc_in && wb_stb_in;
	wire logic rd_take = req && !wb_we_in && !wb_ack_out && clk_en_in;
	wire logic cap_wr  = req && wb_we_in && wb_sel_in[0] && (wb_adr_in[7:2] == ACR_IDX_CTRL_REFCK);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_take;
		req && !wb_ack_out && clk_en_in;
	endsequence
	a_ack_after_req: assert property (s_take |=> wb_ack_out)
		else $error("ack missing after request");
	a_ack_one_pulse: assert property (wb_ack_out && clk_en_in |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	a_ack_needs_req: assert property (!req && clk_en_in |=> !wb_ack_out)
		else $error("ack without request");
	a_upper_bits_zero: assert property (wb_dat_out[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_read_data_hold: assert property ($changed(wb_dat_out) |-> $past(rd_take))
		else $error("read data changed without read");
	a_freeze_when_off: assert property (!clk_en_in |=> $stable(wb_ack_out) && $stable(irq_out))
		else $error("outputs moved while frozen");
	a_cap_follows_write: assert property ($changed(analog_out.sample_cap_select)
		|-> $past(cap_wr) || $past(cap_wr, 2) || $past(cap_wr, 3))
		else $error("capacitor select moved without write");
	a_irq_clear_bus: assert property ($fell(irq_out) |-> $past(req) || $past(req, 2) || $past(req, 3))
		else $error("interrupt dropped without software");
endmodule
bind acr_adc_control acr_adc_control_chk i_acr_adc_control_chk (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
	.clk_en_in(clk_en_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
	.wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
	.analog_out(analog_out), .irq_out(irq_out));
`default_nettype wire

// *** bench/test_adc_control_registers.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_adc_control_registers
	import acr_pkg::*;
;
	logic           clk, rstn, clk_en, cyc, stb, we, standby, valid;
	logic [7:0]     adr;
	logic [3:0]     sel;
	logic [31:0]    wdat;
	logic [9:0]     sdat;
	logic [1:0]     ph;
	logic [15:0]    acc;
	logic [31:0]    rdat;
	logic           ack, cclk, irq;
	acr_analog_type ana;
	logic [31:0]    exp_q[$];
	int             mismatches, check_count;
	// Clock generator.
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	acr_adc_control i_acr_adc_control (.core_clk_in(clk), .rstn_in(rstn), .clk_en_in(clk_en), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .standby_in(standby), .debug_halt_in(1'b0), .start_event_in(1'b0),
		.sample_valid_in(valid), .sample_data_in(sdat), .analog_out(ana), .converter_clk_out(cclk), .irq_out(irq));
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task complete_run;
		if (mismatches == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// One classic Wishbone cycle, held until ack is sampled.
	task bus(input logic [5:0] idx, input logic w, input logic [7:0] d);
		int n;
		@(posedge clk);
		cyc <= 1; stb <= 1; we <= w; adr <= {idx, 2'b00}; wdat <= {24'h000000, d};
		n = 0;
		do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
		check("bus ack", ack, 1);
		if (ack !== 1'b1) complete_run;
		cyc <= 0; stb <= 0; we <= 0;
	endtask
	task wr(input logic [5:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d);
	endtask
	task rd(input logic [5:0] idx, input logic [7:0] e);
		exp_q.push_back({24'h000000, e});
		bus(idx, 1'b0, 8'h00);
	endtask
	task wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
		check("irq raised", irq, 1);
		if (irq !== 1'b1) complete_run;
	endtask
	// Reference, capacitor and divider codes reach the front end.
	task front_end(input logic [7:0] r);
		int n, t;
		wr(ACR_IDX_CTRL_REFCK, r);
		n = 0;
		t = 0;
		repeat (2) @(posedge clk);
		check("reference", ana.reference_select, r[5:4]);
		check("capacitor", ana.sample_cap_select, r[6]);
		while (cclk !== 1'b0 && n < 1100) begin @(posedge clk); n++; end
		while (cclk !== 1'b1 && n < 1100) begin @(posedge clk); n++; end
		while (cclk !== 1'b0 && n < 1100) begin @(posedge clk); n++; t++; end
		while (cclk !== 1'b1 && n < 1100) begin @(posedge clk); n++; t++; end
		check("clock period", t, 32'h2 << r[2:0]);
		if (n >= 1100) complete_run;
	endtask
	// One single conversion in window mode m; e is the flag byte.
	task win_conv(input logic [2:0] m, input logic [1:0] e);
		wr(ACR_IDX_CTRL_WIN, {5'h00, m});
		wr(ACR_IDX_COMMAND, 8'h01);
		wait_irq;
		rd(ACR_IDX_INT_FLAG, {6'h00, e});
	endtask
	// Read results are compared against the oldest noted value.
	always @(posedge clk) if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) check("read data", rdat, exp_q.pop_front());
	// Front end model: one sample every fourth cycle while sampling.
	always @(posedge clk) begin
		ph <= ph + 2'h1;
		valid <= (ana.sample_req === 1'b1) && (ph == 2'h3);
	end
	initial begin
		{cyc, stb, we, standby, valid} = '0;
		adr = 8'h00; wdat = 32'h0; sel = 4'hf; clk_en = 1; sdat = 10'h000; ph = 2'h0;
		rstn = 0; mismatches = 0; check_count = 0;
		void'($urandom(44817));
		repeat (8) @(posedge clk);
		rstn <= 1;
		for (int i = 0; i < 4; i++) rd(6'(i), 8'h00);
		rd(6'h07, 8'h00);
		wr(ACR_IDX_CTRL_MAIN, 8'hfe);
		rd(ACR_IDX_CTRL_MAIN, 8'h86);
		wr(ACR_IDX_CTRL_REFCK, 8'hff);
		rd(ACR_IDX_CTRL_REFCK, 8'h77);
		wr(ACR_IDX_CTRL_REFCK, 8'h00);
		wr(ACR_IDX_COMMAND, 8'h01);
		repeat (20) @(posedge clk);
		check("sample request", ana.sample_req, 0);
		rd(ACR_IDX_COMMAND, 8'h00);
		// Accumulation codes with both depths and a below-window hit.
		wr(ACR_IDX_INT_EN, 8'h01);
		wr(ACR_IDX_WLOW_LO, 8'hff);
		wr(ACR_IDX_WLOW_HI, 8'hff);
		wr(ACR_IDX_CTRL_WIN, 8'h01);
		for (int c = 0; c < 7; c++) begin
			sdat <= 10'($urandom_range(1023, 0));
			wr(ACR_IDX_CTRL_MAIN, c[0] ? 8'h05 : 8'h01);
			wr(ACR_IDX_CTRL_ACC, 8'(c));
			acc = (16'h0001 << c) * (c[0] ? 16'(sdat[9:2]) : 16'(sdat));
			wr(ACR_IDX_COMMAND, 8'h01);
			if (c > 1) rd(ACR_IDX_COMMAND, 8'h01);
			wait_irq;
			rd(ACR_IDX_COMMAND, 8'h00);
			rd(ACR_IDX_INT_FLAG, 8'h03);
			repeat (4) @(posedge clk);
			check("irq cleared", irq, 0);
			rd(ACR_IDX_RESULT_LO, acc[7:0]);
			rd(ACR_IDX_RESULT_HI, acc[15:8]);
		end
		front_end({1'b0, 1'($urandom), 2'($urandom_range(1, 0)), 1'b0, 3'($urandom)});
		// Window modes against thresholds 0x0100 and 0x0200.
		wr(ACR_IDX_CTRL_ACC, 8'h00);
		wr(ACR_IDX_WLOW_LO, 8'h00);
		wr(ACR_IDX_WLOW_HI, 8'h01);
		wr(ACR_IDX_WHIGH_LO, 8'h00);
		wr(ACR_IDX_WHIGH_HI, 8'h02);
		sdat <= 10'h180;
		win_conv(ACR_WIN_ABOVE, 2'h1);
		win_conv(ACR_WIN_INSIDE, 2'h3);
		sdat <= 10'h300;
		win_conv(ACR_WIN_OUTSIDE, 2'h3);
		win_conv(ACR_WIN_ABOVE, 2'h3);
		// Continuous conversion restarts without a new trigger.
		wr(ACR_IDX_CTRL_WIN, 8'h00);
		wr(ACR_IDX_CTRL_ACC, 8'h00);
		wr(ACR_IDX_CTRL_MAIN, 8'h03);
		wr(ACR_IDX_COMMAND, 8'h01);
		wait_irq;
		rd(ACR_IDX_INT_FLAG, 8'h01);
		wait_irq;
		rd(ACR_IDX_COMMAND, 8'h01);
		wr(ACR_IDX_CTRL_MAIN, 8'h00);
		rd(ACR_IDX_COMMAND, 8'h00);
		bus(ACR_IDX_INT_FLAG, 1'b0, 8'h00);
		// Standby freezes the sequencer unless the run bit is set.
		clk_en <= 0;
		repeat (3) @(posedge clk);
		clk_en <= 1;
		wr(ACR_IDX_CTRL_REFCK, 8'h00);
		wr(ACR_IDX_CTRL_DLY, 8'h20);
		wr(ACR_IDX_CTRL_MAIN, 8'h01);
		standby <= 1;
		wr(ACR_IDX_COMMAND, 8'h01);
		repeat (100) @(posedge clk);
		check("standby irq", irq, 0);
		standby <= 0;
		repeat (20) @(posedge clk);
		check("startup delay", irq, 0);
		wait_irq;
		bus(ACR_IDX_INT_FLAG, 1'b0, 8'h00);
		wr(ACR_IDX_CTRL_MAIN, 8'h81);
		standby <= 1;
		wr(ACR_IDX_COMMAND, 8'h01);
		wait_irq;
		complete_run;
	end
endmodule
`default_nettype wire
